// [hdl/eewa_program_all.sv]
// Program-all engine of a three-wire serial EEPROM with status output
`timescale 1ns/1ps
module eewa_program_all
  import eewa_pkg::*;
#(
  parameter int unsigned PROGRAM_CYCLES_P = eewa_pkg::PROGRAM_CYCLES,
  parameter int unsigned WORDS = eewa_pkg::WORDS_X16
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Serial pins from the host
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  input wire logic select_pin,
  // Organisation strap: 1 = 16-bit words, 0 = bytes
  input wire logic word_width_select,
  // Serial output pin and its output enable
  output logic serial_out_pin,
  output logic serial_out_oe,
  // Status outputs
  output logic program_busy,
  output logic unlocked,
  // Memory read port for observing stored words
  input wire logic [7:0] mem_addr,
  output logic [15:0] mem_rdata
);
  import eewa_pkg::*;

  // Elaboration check: the read address is 8 bits, so at most 256 words
  if (PROGRAM_CYCLES_P < 1 || WORDS < 1 || WORDS > 256) begin : g_bad_param
    $error("eewa_program_all: bad parameter");
  end

  eewa_pins_if pins ();

  // Pin edge detection
  eewa_pin_sampler u_sampler (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .serial_clock_pin(serial_clock_pin),
    .serial_in_pin(serial_in_pin),
    .select_pin(select_pin),
    .pins(pins)
  );

  eewa_state_t state; // Decoder state
  logic [27:0] shreg; // Received bits, newest in bit 0
  logic [4:0] nbits; // Bits received after start bit
  logic [31:0] prog_cnt; // Remaining program cycles
  logic [15:0] prog_data; // Word being programmed
  logic [15:0] mem [WORDS]; // Storage array
  logic [4:0] cmd_len; // Bits for a full program-all frame
  logic [4:0] hdr_len; // Bits up to end of the address field
  logic [1:0] opc; // Opcode field
  logic [1:0] sub; // Address leading pattern

  // Frame length depends on organisation strap
  always_comb begin
    if (word_width_select) begin
      hdr_len = 5'(HEADER_BITS - 1 + ADDR_BITS_X16);
      cmd_len = 5'(HEADER_BITS - 1 + ADDR_BITS_X16 + DATA_BITS_X16);
    end else begin
      hdr_len = 5'(HEADER_BITS - 1 + ADDR_BITS_X8);
      cmd_len = 5'(HEADER_BITS - 1 + ADDR_BITS_X8 + DATA_BITS_X8);
    end
  end

  // Opcode and pattern sit at fixed depth from the newest bit
  // Read while the last header bit is still arriving, so one bit shallower
  always_comb begin
    if (word_width_select) begin
      opc = shreg[8:7];
      sub = shreg[6:5];
    end else begin
      opc = shreg[9:8];
      sub = shreg[7:6];
    end
  end

  // Instruction decoder and program sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= EEWA_IDLE;
      shreg <= '0;
      nbits <= '0;
      prog_cnt <= '0;
      prog_data <= '0;
    end else if (clk_en) begin
      case (state)
        EEWA_IDLE: begin
          // Wait for start bit while selected
          if (pins.sel && pins.clk_rise && pins.data_bit == START_BIT) begin
            state <= EEWA_SHIFT;
            nbits <= '0;
            shreg <= '0;
          end
        end
        EEWA_SHIFT: begin
          if (!pins.sel) begin
            state <= EEWA_IDLE;
          end else if (pins.clk_rise) begin
            shreg <= {shreg[26:0], pins.data_bit};
            nbits <= nbits + 5'h1;
            if (nbits + 5'h1 == hdr_len) begin
              // Header complete: decide what this frame is
              state <= EEWA_IGNORE;
              if (opc == OPC_EXT && sub == SUB_PROGRAM_ALL && unlocked) begin
                state <= EEWA_SHIFT;
              end
            end else if (nbits + 5'h1 == cmd_len) begin
              // Full word received; arm on deselect
              prog_data <= word_width_select ? {shreg[14:0], pins.data_bit}
                                             : {8'h00, shreg[6:0], pins.data_bit};
              state <= EEWA_WAIT_DESEL;
            end
          end
        end
        EEWA_WAIT_DESEL: begin
          // Extra clocks after the word cancel the command
          if (pins.sel_fall) begin
            state <= EEWA_PROGRAM;
            prog_cnt <= PROGRAM_CYCLES_P;
          end else if (pins.sel && pins.clk_rise) begin
            state <= EEWA_IGNORE;
          end
        end
        EEWA_PROGRAM: begin
          // Self-timed: counts system clock only, no serial clock needed
          if (prog_cnt <= 32'h1) begin
            state <= EEWA_IDLE;
            prog_cnt <= '0;
          end else begin
            prog_cnt <= prog_cnt - 32'h1;
          end
          // Serial traffic is not decoded here
        end
        EEWA_IGNORE: begin
          // Rest of a frame we do not execute, until deselect
          if (!pins.sel) begin
            state <= EEWA_IDLE;
          end
        end
        default: state <= EEWA_IDLE;
      endcase
    end
  end

  // Unlock flag; lock and unlock commands are recognised from the header
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      unlocked <= UNLOCK_RESET;
    end else if (clk_en && state == EEWA_SHIFT && pins.sel && pins.clk_rise
                 && nbits + 5'h1 == hdr_len && opc == OPC_EXT) begin
      if (sub == SUB_UNLOCK) begin
        unlocked <= 1'b1;
      end else if (sub == SUB_LOCK) begin
        unlocked <= 1'b0;
      end
    end
  end

  // Storage: every location written in the first program cycle; old content ignored
  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++) begin : g_word
      always_ff @(posedge sys_clk) begin
        if (clk_en && state == EEWA_PROGRAM && prog_cnt == PROGRAM_CYCLES_P) begin
          mem[gi] <= prog_data;
        end
      end
    end
  endgenerate

  // Registered read port
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mem_rdata <= '0;
    end else if (clk_en) begin
      mem_rdata <= mem[mem_addr];
    end
  end

  // Busy flag: program phase except its last count (prog_cnt of 1), registered so it rises one cycle late
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      program_busy <= 1'b0;
    end else if (clk_en) begin
      program_busy <= (state == EEWA_PROGRAM) && (prog_cnt > 32'h1);
    end
  end

  // Status on the serial output while selected around a program
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      serial_out_pin <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (clk_en) begin
      if (state == EEWA_PROGRAM && pins.sel) begin
        serial_out_oe <= 1'b1;
        serial_out_pin <= (prog_cnt <= 32'h1);
      end else if (state == EEWA_IDLE && pins.sel && serial_out_oe) begin
        // Ready shown until the next rising edge of the serial clock
        serial_out_pin <= 1'b1;
        serial_out_oe <= !pins.clk_rise;
      end else begin
        serial_out_oe <= 1'b0;
        serial_out_pin <= 1'b0;
      end
    end
  end
endmodule // eewa_program_all

// [hdl/eewa_pkg.sv]
// Package for the serial EEPROM program-all block: timing, opcodes and widths
package eewa_pkg;
  // System clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Self-timed program duration, ms as printed
  localparam int unsigned PROGRAM_TIME_MS = 5;
  // Program time in cycles, longest time rounds down
  localparam int unsigned PROGRAM_CYCLES = (PROGRAM_TIME_MS * 1000000) / CLK_PERIOD_NS;
  // Minimum deselect time in ns (0.25 us)
  localparam int unsigned MIN_DESELECT_NS = 250;
  // Minimum deselect in cycles, least time rounds up
  localparam int unsigned MIN_DESELECT_CYCLES = (MIN_DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Start bit value
  localparam logic START_BIT = 1'b1;
  // Opcode of the extended group
  localparam logic [1:0] OPC_EXT = 2'h0;
  // Address leading patterns in extended group
  localparam logic [1:0] SUB_PROGRAM_ALL = 2'h1;
  localparam logic [1:0] SUB_UNLOCK = 2'h3;
  localparam logic [1:0] SUB_LOCK = 2'h0;
  // Address bits for each organisation
  localparam int unsigned ADDR_BITS_X8 = 9;
  localparam int unsigned ADDR_BITS_X16 = 8;
  // Data bits for each organisation
  localparam int unsigned DATA_BITS_X8 = 8;
  localparam int unsigned DATA_BITS_X16 = 16;
  // Header length: start + opcode
  localparam int unsigned HEADER_BITS = 3;
  // Memory locations
  localparam int unsigned WORDS_X16 = 256;
  // Reset value of the unlock flag (locked)
  localparam logic UNLOCK_RESET = 1'b0;
  // Decoder states
  typedef enum logic [2:0] {
    EEWA_IDLE,
    EEWA_SHIFT,
    EEWA_WAIT_DESEL,
    EEWA_PROGRAM,
    EEWA_IGNORE
  } eewa_state_t;
endpackage

// [hdl/eewa_pins_if.sv]
// Interface carrying sampled serial pins from the edge detector to the core
`timescale 1ns/1ps
interface eewa_pins_if;
  logic clk_rise; // One-cycle pulse on serial clock rising edge
  logic data_bit; // Serial input value at that edge
  logic sel; // Device select level
  logic sel_fall; // One-cycle pulse on select falling edge
  modport src (output clk_rise, output data_bit, output sel, output sel_fall);
  modport dst (input clk_rise, input data_bit, input sel, input sel_fall);
endinterface

// [hdl/eewa_pin_sampler.sv]
// Edge detector for the host-driven serial clock and device select
`timescale 1ns/1ps
module eewa_pin_sampler (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Raw pins
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  input wire logic select_pin,
  // Sampled events
  eewa_pins_if.src pins
);
  import eewa_pkg::*;
  logic clk_q; // Previous serial clock level
  logic sel_q; // Previous select level

  // Remember last levels; pins are synchronous so no extra stages
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clk_q <= 1'b0;
      sel_q <= 1'b0;
    end else if (clk_en) begin
      clk_q <= serial_clock_pin;
      sel_q <= select_pin;
    end
  end

  // Edge pulses are gated by enable so a frozen block sees none
  assign pins.clk_rise = clk_en & serial_clock_pin & ~clk_q;
  assign pins.data_bit = serial_in_pin;
  assign pins.sel = select_pin;
  assign pins.sel_fall = clk_en & sel_q & ~select_pin;
endmodule // eewa_pin_sampler

// [tb/eewa_host_model.sv]
// Host model driving the serial bus of the program-all block
`timescale 1ns/1ps
module eewa_host_model
  import eewa_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Status from the device
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  // Serial bus driven by the host
  output logic serial_clock_pin,
  output logic serial_in_pin,
  output logic select_pin
);
  // Bus idle, clock still
  initial begin
    serial_clock_pin = 1'b0;
    serial_in_pin = 1'b0;
    select_pin = 1'b0;
  end
  // One frame MSB first; clock stays low afterwards
  task automatic send(input logic [26:0] b, input int n);
    select_pin = 1'b1;
    repeat (2) @(negedge sys_clk);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_pin = b[i];
      repeat (3) @(negedge sys_clk);
      serial_clock_pin = 1'b1;
      repeat (3) @(negedge sys_clk);
      serial_clock_pin = 1'b0;
    end
    // Data no longer valid, so it flips
    serial_in_pin = ~serial_in_pin;
    repeat (2) @(negedge sys_clk);
    select_pin = 1'b0;
    repeat (MIN_DESELECT_CYCLES) @(negedge sys_clk);
  endtask
  // Select and watch status, bounded wait
  task automatic poll(output int low_n, output bit ready);
    low_n = 0;
    ready = 1'b0;
    select_pin = 1'b1;
    for (int i = 0; i < 600 && !ready; i++) begin
      @(negedge sys_clk);
      if (serial_out_oe === 1'b1 && serial_out_pin === 1'b0) low_n++;
      ready = serial_out_oe === 1'b1 && serial_out_pin === 1'b1;
    end
    select_pin = 1'b0;
    repeat (MIN_DESELECT_CYCLES) @(negedge sys_clk);
  endtask
endmodule // eewa_host_model

// [tb/eewa_program_all_asserts.sv]
// Port-level checks of the program-all block
`timescale 1ns/1ps
module eewa_program_all_asserts #(
  parameter int unsigned PROGRAM_CYCLES_P = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Host side
  input wire logic select_pin,
  // Device outputs
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic program_busy,
  input wire logic unlocked
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Busy cycles so far, cleared when idle
  int unsigned run;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) run <= 0;
    else run <= program_busy ? run + 1 : 0;
  end
  chk_busy_len: assert property (
    $fell(program_busy) |-> run == PROGRAM_CYCLES_P - 1) else $error("program time wrong");
  chk_start_unlocked: assert property (
    $rose(program_busy) |-> unlocked && !select_pin) else $error("program while locked");
  chk_start_desel: assert property (
    $rose(program_busy) |-> $past(select_pin, 2) || $past(select_pin, 3)
    || $past(select_pin, 4) || $past(select_pin, 5)) else $error("start not on deselect");
  chk_busy_low: assert property (
    program_busy && serial_out_oe |-> !serial_out_pin) else $error("ready shown while busy");
  chk_ready_high: assert property (
    !$past(program_busy) && !program_busy && serial_out_oe |-> serial_out_pin)
    else $error("busy shown while ready");
  chk_oe_sel: assert property (
    serial_out_oe |-> $past(select_pin) || $past(select_pin, 2) || $past(select_pin, 3))
    else $error("output driven while deselected");
  chk_lock_hold: assert property (
    program_busy |-> $stable(unlocked)) else $error("command decoded during program");
  chk_unlock_sel: assert property (
    $rose(unlocked) |-> $past(select_pin, 2)) else $error("unlock outside a frame");
  chk_reset_out: assert property (disable iff (1'b0)
    !rst_n |=> !program_busy && !unlocked && !serial_out_oe) else $error("reset state wrong");
  // Main scenarios reached
  cov_prog: cover property ($rose(program_busy));
  cov_unlock: cover property ($rose(unlocked));
  cov_ready: cover property (serial_out_oe && serial_out_pin);
endmodule // eewa_program_all_asserts
bind eewa_program_all eewa_program_all_asserts #(.PROGRAM_CYCLES_P(PROGRAM_CYCLES_P))
  i_eewa_program_all_asserts (.sys_clk, .rst_n, .select_pin, .serial_out_pin,
  .serial_out_oe, .program_busy, .unlocked);

// [tb/tb_eewa_program_all.sv]
// Self-checking bench of the program-all block
`timescale 1ns/1ps
module tb_eewa_program_all;
  import eewa_pkg::*;
  // Short program, still outlasts a deselect plus one frame
  localparam int unsigned PCYC = 300;
  logic sys_clk, rst_n, clk_en, serial_clock_pin, serial_in_pin, select_pin;
  logic word_width_select, serial_out_pin, serial_out_oe, program_busy, unlocked;
  logic [7:0] mem_addr;
  logic [15:0] mem_rdata;
  int n_mismatch, total_checks, busy_cyc, low_n;
  bit rdy;
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Busy cycle count, cleared by the scenarios
  always @(posedge sys_clk) if (program_busy === 1'b1) busy_cyc <= busy_cyc + 1;
  eewa_host_model i_eewa_host_model (.sys_clk, .serial_out_pin, .serial_out_oe,
    .serial_clock_pin, .serial_in_pin, .select_pin);
  eewa_program_all #(.PROGRAM_CYCLES_P(PCYC), .WORDS(WORDS_X16)) i_eewa_program_all (
    .sys_clk, .rst_n, .clk_en, .serial_clock_pin, .serial_in_pin, .select_pin,
    .word_width_select, .serial_out_pin, .serial_out_oe, .program_busy, .unlocked,
    .mem_addr, .mem_rdata);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Words at both ends and between
  task automatic mem_all(input logic [15:0] exp);
    for (int a = 0; a < 256; a += 85) begin
      mem_addr = a[7:0];
      @(negedge sys_clk);
      check("word", mem_rdata, exp);
    end
  endtask
  // Program-all frame, poll, then judge time and contents
  task automatic prog(input logic [26:0] f, input int n, input logic [15:0] exp);
    busy_cyc = 0;
    i_eewa_host_model.send(f, n);
    i_eewa_host_model.poll(low_n, rdy);
    check("ready", rdy, 1'b1);
    if (!rdy) stop_test();
    check("busy seen", low_n > 0, 1'b1);
    // Busy drops at the edge that ends the last program cycle, the same edge that first shows ready
    check("busy len", busy_cyc[15:0], 16'(PCYC - 1));
    mem_all(exp);
  endtask
  task automatic t_locked;
    check("oe", serial_out_oe, 1'b0);
    check("unlocked", unlocked, 1'b0);
    busy_cyc = 0;
    i_eewa_host_model.send({5'h11, 6'h15, 16'h1234}, 27);
    check("locked busy", busy_cyc[15:0], 16'h0000);
    $display("locked done");
  endtask
  task automatic t_program;
    i_eewa_host_model.send({16'h0000, 5'h13, 6'h00}, 11);
    check("unlock", unlocked, 1'b1);
    prog({5'h11, 6'h2a, 16'ha5c3}, 27, 16'ha5c3);
    prog({5'h11, 6'h00, 16'h0ff0}, 27, 16'h0ff0);
    $display("program done");
  endtask
  // Lock frame sent while the program runs is ignored
  task automatic t_busy_frame;
    i_eewa_host_model.send({5'h11, 6'h15, 16'h5aa5}, 27);
    i_eewa_host_model.send({16'h0000, 5'h10, 6'h00}, 11);
    check("lock ignored", unlocked, 1'b1);
    i_eewa_host_model.poll(low_n, rdy);
    check("busy ready", rdy, 1'b1);
    if (!rdy) stop_test();
    check("busy status", low_n > 0, 1'b1);
    mem_all(16'h5aa5);
    $display("busy frame done");
  endtask
  task automatic t_lock;
    i_eewa_host_model.send({16'h0000, 5'h10, 6'h00}, 11);
    check("locked", unlocked, 1'b0);
    busy_cyc = 0;
    i_eewa_host_model.send({5'h11, 6'h15, 16'h1111}, 27);
    check("relock busy", busy_cyc[15:0], 16'h0000);
    mem_all(16'h5aa5);
    $display("lock done");
  endtask
  // Byte organisation: nine address bits, eight data bits
  task automatic t_bytes;
    word_width_select = 1'b0;
    i_eewa_host_model.send({15'h0000, 5'h13, 7'h00}, 12);
    prog({7'h00, 5'h11, 7'h2a, 8'h3c}, 20, 16'h003c);
    $display("bytes done");
  endtask
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    word_width_select = 1'b1;
    mem_addr = 8'h00;
    busy_cyc = 0;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_locked();
    t_program();
    t_busy_frame();
    t_lock();
    t_bytes();
    stop_test();
  end
endmodule // tb_eewa_program_all
